/* verilog/option_word_defines.svh */
// option word decoder constants: offsets, field positions, erased values, timing
// assumes 32-bit option memory words and a 25 MHz system clock
`ifndef OPTION_WORD_DEFINES_SVH
`define OPTION_WORD_DEFINES_SVH

`define OPT_ERASED_WORD 32'hFFFF_FFFF
`define OPT_ADDR_BYTE_ORDER 32'hFFFF_FF80
`define OPT_ADDR_STARTUP 32'hFFFF_FF88
`define REG_ADDR_BYTE_ORDER 4'h0
`define REG_ADDR_STARTUP 4'h2
`define REG_ADDR_STATUS 4'h4
`define REG_ADDR_CLK_SEL 4'h5
`define REG_ADDR_FAULT 4'h6
`define FLD_LEVEL_LSB 0
`define FLD_LEVEL_MSB 1
`define FLD_MON0_OFF 2
`define FLD_FAST_OSC_OFF 8
`define FLD_BYTE_ORDER_MSB 2
`define BYTE_ORDER_BIG 3'h0
`define BYTE_ORDER_LITTLE 3'h7
`define LEVEL_3V84 2'h0
`define LEVEL_2V82 2'h1
`define LEVEL_2V51 2'h2
`define CLK_SEL_RESET 3'h0
`define CLK_SEL_W 3
`define CLK_PERIOD_NS 40
`define FAST_OSC_SETTLE_NS 150000
`define MON0_RELEASE_NS 100000
`define CYCLES_LEAST(ns) ((ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* verilog/option_word_pkg.sv */
// types shared by the option word decoder
// assumes nothing of its surroundings
package option_word_pkg;
    typedef enum logic [2:0] {
        LOAD_IDLE = 3'b000,
        LOAD_BYTE_ORDER = 3'b001,
        LOAD_STARTUP = 3'b010,
        LOAD_SETTLE = 3'b011,
        LOAD_DONE = 3'b100
    } load_state_e;
endpackage

/* verilog/release_timer.sv */
// down counter that holds a release line off for a programmed number of cycles
// assumes a synchronous, active-high reset on the same clock
`timescale 1ns/10ps
module release_timer
    import option_word_pkg::*;
#(
    parameter int COUNT = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic hold,
    // status
    output logic done
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] count;
    wire logic [W-1:0] next_count = (count == '0) ? count : count - W'(1);

    always_ff @(posedge clk) begin
        if (rst || hold) begin
            count <= W'(COUNT);
            done <= 1'b0;
        end else begin
            count <= next_count;
            done <= (count == '0);
        end
    end
endmodule // release_timer

/* verilog/option_word_startup_decode.sv */
// start-up option word decoder: loads two option words after reset and drives settings
// assumes a single-cycle option memory read port and an Avalon-MM register master
`timescale 1ns/10ps
`include "option_word_defines.svh"
module option_word_startup_decode
    import option_word_pkg::*;
#(
    parameter int SETTLE_CYCLES = `CYCLES_LEAST(`FAST_OSC_SETTLE_NS),
    parameter int MON0_RELEASE_CYCLES = `CYCLES_LEAST(`MON0_RELEASE_NS)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // option memory read port
    output logic [31:0] opt_addr,
    output logic opt_rd,
    input wire logic [31:0] opt_rdata,
    input wire logic opt_block_erased,
    // pins
    input wire logic boot_mode_pin,
    input wire logic monitor0_below_pin,
    // decoded settings
    output logic [1:0] monitor0_level_sel,
    output logic monitor0_reset_start,
    output logic fast_osc_early_enable,
    output logic [2:0] byte_order_sel,
    output logic big_endian,
    output logic byte_order_bad,
    output logic [2:0] sysclk_source_sel,
    // reset outputs
    output logic monitor0_reset,
    output logic cpu_release,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    load_state_e state;
    load_state_e next_state;
    logic [31:0] startup_option_word;
    logic [31:0] byte_order_option_word;
    logic boot_meta;
    logic boot_sync;
    logic below_meta;
    logic below_sync;
    logic settle_hold;
    logic settle_done;
    logic mon0_hold;
    logic mon0_done;
    logic answered;

    // pin synchronisers: only the second stage is read by any logic
    always_ff @(posedge clk) begin
        if (rst) begin
            boot_meta <= 1'b0;
            boot_sync <= 1'b0;
        end else begin
            boot_meta <= boot_mode_pin;
            boot_sync <= boot_meta;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            below_meta <= 1'b0;
            below_sync <= 1'b0;
        end else begin
            below_meta <= monitor0_below_pin;
            below_sync <= below_meta;
        end
    end

    // erased block reads as all ones; boot mode overrides the start-up word
    wire logic [31:0] mem_word = opt_block_erased ? `OPT_ERASED_WORD : opt_rdata;
    wire logic [31:0] startup_in = boot_sync ? `OPT_ERASED_WORD : mem_word;
    wire logic [1:0] level_field = startup_option_word[`FLD_LEVEL_MSB:`FLD_LEVEL_LSB];
    wire logic mon0_off = startup_option_word[`FLD_MON0_OFF];
    wire logic osc_off = startup_option_word[`FLD_FAST_OSC_OFF];
    wire logic [2:0] order_field = byte_order_option_word[`FLD_BYTE_ORDER_MSB:0];
    wire logic order_big = (order_field == `BYTE_ORDER_BIG);
    wire logic order_ok = order_big || (order_field == `BYTE_ORDER_LITTLE);
    wire logic level_ok = (level_field == `LEVEL_3V84) || (level_field == `LEVEL_2V82)
        || (level_field == `LEVEL_2V51);
    wire logic load_done = (state == LOAD_DONE);
    wire logic mon0_active = load_done && !mon0_off;

    // loader sequence: byte-order word, start-up word, then oscillator settling
    always_comb begin
        unique case (state)
            LOAD_IDLE: next_state = LOAD_BYTE_ORDER;
            LOAD_BYTE_ORDER: next_state = LOAD_STARTUP;
            LOAD_STARTUP: next_state = LOAD_SETTLE;
            LOAD_SETTLE: next_state = (osc_off || settle_done) ? LOAD_DONE : LOAD_SETTLE;
            LOAD_DONE: next_state = LOAD_DONE;
            default: next_state = LOAD_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= LOAD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // words captured once after reset; the bus has no path into them
    always_ff @(posedge clk) begin
        if (rst) begin
            byte_order_option_word <= `OPT_ERASED_WORD;
        end else if (state == LOAD_BYTE_ORDER) begin
            byte_order_option_word <= mem_word;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            startup_option_word <= `OPT_ERASED_WORD;
        end else if (state == LOAD_STARTUP) begin
            startup_option_word <= startup_in;
        end
    end

    // memory read requests, one cycle before capture
    wire logic [31:0] next_opt_addr = (next_state == LOAD_STARTUP) ? `OPT_ADDR_STARTUP : `OPT_ADDR_BYTE_ORDER;
    wire logic next_opt_rd = (next_state == LOAD_BYTE_ORDER) || (next_state == LOAD_STARTUP);

    always_ff @(posedge clk) begin
        if (rst) begin
            opt_addr <= `OPT_ADDR_BYTE_ORDER;
        end else begin
            opt_addr <= next_opt_addr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            opt_rd <= 1'b0;
        end else begin
            opt_rd <= next_opt_rd;
        end
    end

    assign settle_hold = (state != LOAD_SETTLE) || osc_off;
    assign mon0_hold = !mon0_active || below_sync;

    release_timer #(
        .COUNT(SETTLE_CYCLES)
    ) u_settle (
        .clk(clk),
        .rst(rst),
        .hold(settle_hold),
        .done(settle_done)
    );

    release_timer #(
        .COUNT(MON0_RELEASE_CYCLES)
    ) u_mon0 (
        .clk(clk),
        .rst(rst),
        .hold(mon0_hold),
        .done(mon0_done)
    );

    // decoded settings, held until the next reset
    // flags wait until the byte-order word is in, so the erased defaults never flash a fault
    wire logic words_loaded = (state != LOAD_IDLE) && (state != LOAD_BYTE_ORDER);

    always_ff @(posedge clk) begin
        if (rst) begin
            monitor0_level_sel <= `LEVEL_3V84;
        end else begin
            monitor0_level_sel <= level_field;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            monitor0_reset_start <= 1'b0;
        end else begin
            monitor0_reset_start <= !mon0_off && words_loaded;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fast_osc_early_enable <= 1'b0;
        end else begin
            fast_osc_early_enable <= !osc_off && (state == LOAD_SETTLE || load_done);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            byte_order_sel <= `BYTE_ORDER_LITTLE;
        end else begin
            byte_order_sel <= order_field;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            big_endian <= 1'b0;
        end else begin
            big_endian <= order_big;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            byte_order_bad <= 1'b0;
        end else begin
            byte_order_bad <= !order_ok && words_loaded;
        end
    end

    // monitor-0 reset: asserted while low, released after a fixed delay; no flag, no interrupt
    always_ff @(posedge clk) begin
        if (rst) begin
            monitor0_reset <= 1'b0;
        end else begin
            monitor0_reset <= mon0_active && !mon0_done;
        end
    end

    // release and monitor reset change on the same edge, so the CPU never runs under reset
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_release <= 1'b0;
        end else begin
            cpu_release <= load_done && (mon0_off || mon0_done);
        end
    end

    // avalon-mm slave: one wait cycle, then the answer
    // a write lands only at the answer edge, so a request held through its wait cycle lands once; one held on lands again every second cycle
    wire logic bus_req = avs_read || avs_write;
    wire logic byte_order_hit = avs_address == `REG_ADDR_BYTE_ORDER;
    wire logic startup_hit = avs_address == `REG_ADDR_STARTUP;
    wire logic status_hit = avs_address == `REG_ADDR_STATUS;
    wire logic clk_sel_hit = avs_address == `REG_ADDR_CLK_SEL;
    wire logic clk_sel_wr = avs_write && answered && clk_sel_hit && avs_byteenable[0];
    wire logic [31:0] status_word = {29'h0000_0000, byte_order_bad, !level_ok && mon0_active, load_done};
    wire logic [31:0] read_mux =
        byte_order_hit ? byte_order_option_word :
        startup_hit ? startup_option_word :
        status_hit ? status_word :
        clk_sel_hit ? {29'h0000_0000, sysclk_source_sel} :
        32'h0000_0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            answered <= 1'b0;
        end else begin
            answered <= bus_req && !answered;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(bus_req && !answered);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_readdata <= read_mux;
        end
    end

    // only a CPU write changes the clock source, never the option word
    always_ff @(posedge clk) begin
        if (rst) begin
            sysclk_source_sel <= `CLK_SEL_RESET;
        end else if (clk_sel_wr) begin
            sysclk_source_sel <= avs_writedata[`CLK_SEL_W-1:0];
        end
    end
endmodule // option_word_startup_decode

/* test/option_word_chk.sv */
// assertions on the option word decoder ports
// assumes bind to option_word_startup_decode
`timescale 1ns/10ps
module option_word_chk #(
    parameter int SETTLE_CYCLES = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // option memory and bus
    input wire logic opt_rd,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_address,
    input wire logic avs_waitrequest,
    // settings
    input wire logic [1:0] monitor0_level_sel,
    input wire logic monitor0_reset_start,
    input wire logic fast_osc_early_enable,
    input wire logic [2:0] byte_order_sel,
    input wire logic big_endian,
    input wire logic byte_order_bad,
    input wire logic [2:0] sysclk_source_sel,
    input wire logic monitor0_reset,
    input wire logic cpu_release
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [15:0] since_rd;
    wire wr5 = avs_write && avs_address == 4'h5;
    always_ff @(posedge clk) begin
        if (rst || opt_rd) since_rd <= 16'h0000;
        else if (since_rd != 16'hFFFF) since_rd <= since_rd + 16'h0001;
    end
    bus_answer_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest) else $error("no answer");
    answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
    clk_src_a: assert property (!(wr5 || $past(wr5)) |=> $stable(sysclk_source_sel)) else $error("src moved");
    big_end_a: assert property (cpu_release |-> big_endian == (byte_order_sel == 3'h0)) else $error("endian");
    bad_order_a: assert property (cpu_release |-> byte_order_bad == !(byte_order_sel inside {3'h0, 3'h7}))
        else $error("bad order flag");
    mon_off_a: assert property (!monitor0_reset_start |-> !monitor0_reset) else $error("monitor off reset");
    mon_hold_a: assert property (monitor0_reset |-> !cpu_release) else $error("released in reset");
    settle_a: assert property ($rose(cpu_release) && fast_osc_early_enable |-> since_rd >= SETTLE_CYCLES)
        else $error("settle short");
    hold_set_a: assert property (cpu_release |=> $stable({monitor0_level_sel, fast_osc_early_enable,
        byte_order_sel})) else $error("settings moved");
    cover property ($rose(cpu_release) && fast_osc_early_enable);
    cover property ($rose(monitor0_reset));
    cover property (wr5 && !avs_waitrequest);
endmodule // option_word_chk
bind option_word_startup_decode option_word_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) option_word_chk_inst (
    .clk, .rst, .opt_rd, .avs_read, .avs_write, .avs_address, .avs_waitrequest,
    .monitor0_level_sel, .monitor0_reset_start, .fast_osc_early_enable, .byte_order_sel,
    .big_endian, .byte_order_bad, .sysclk_source_sel, .monitor0_reset, .cpu_release);

/* test/option_mem_model.sv */
// option memory model: two programmed words, answered combinationally
// assumes the words are set by the bench before a reset
`timescale 1ns/10ps
module option_mem_model (
    input wire logic clk,
    input wire logic [31:0] opt_addr,
    input wire logic opt_rd,
    input wire logic [31:0] bo_word,
    input wire logic [31:0] st_word,
    output logic [31:0] opt_rdata
);
    // words stay fixed between resets: programmed once
    wire [31:0] sel = (opt_addr == 32'hFFFF_FF80) ? bo_word : st_word;
    // idle data toggles so a late sample never matches
    assign opt_rdata = opt_rd ? sel : (32'h5A5A_A5A5 ^ {32{clk}});
endmodule // option_mem_model

/* test/testbench.sv */
// self-checking bench for the option word decoder
// assumes the option memory model and the bound checker
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD %0t mismatch %h %h", $time, a, b); end end
module testbench;
    logic clk = 0, rst = 1, rd = 0, wr = 0, erased = 0, boot = 0, below = 0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000, bo = 32'hFFFF_FFFF, st = 32'hFFFF_FFFF;
    logic [31:0] rdata, oaddr, odata, q;
    logic ord, lrs, fast, big, bad, mres, rel, wait_n;
    logic [1:0] lvl;
    logic [2:0] bsel, src;
    int bad_count = 0, checks = 0, cyc = 0, n;
    always #20 clk = ~clk;
    option_mem_model option_mem_model_inst (.clk(clk), .opt_addr(oaddr), .opt_rd(ord),
        .bo_word(bo), .st_word(st), .opt_rdata(odata));
    option_word_startup_decode #(.SETTLE_CYCLES(4), .MON0_RELEASE_CYCLES(4)) option_word_startup_decode_inst (
        .clk(clk), .rst(rst), .opt_addr(oaddr), .opt_rd(ord), .opt_rdata(odata),
        .opt_block_erased(erased), .boot_mode_pin(boot), .monitor0_below_pin(below),
        .monitor0_level_sel(lvl), .monitor0_reset_start(lrs), .fast_osc_early_enable(fast),
        .byte_order_sel(bsel), .big_endian(big), .byte_order_bad(bad), .sysclk_source_sel(src),
        .monitor0_reset(mres), .cpu_release(rel), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wait_n));
    task final_report;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            final_report;
        end
    end
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        while (wait_n !== 1'b0) @(posedge clk);
        r = rdata;
        rd <= 0;
        wr <= 0;
        @(posedge clk);
    endtask
    task reboot(input logic [31:0] b, input logic [31:0] s);
        bo <= b;
        st <= s;
        rst <= 1;
        repeat (8) @(posedge clk);
        rst <= 0;
        for (n = 0; n < 300 && rel !== 1'b1; n++) @(posedge clk);
        `CHK(rel, 1'b1)
    endtask
    task t_level;
        for (int i = 0; i < 4; i++) begin
            reboot(32'hFFFF_FFFF, 32'hFFFF_FEF8 | i);
            `CHK(lvl, i[1:0])
            `CHK({lrs, fast, src}, 5'b11_000)
            bus(0, 4'h2, 0, q);
            `CHK(q, 32'hFFFF_FEF8 | i)
            bus(0, 4'h4, 0, q);
            `CHK(q, {29'h0000_0000, 1'b0, i == 3, 1'b1})
        end
    endtask
    task t_blank;
        reboot(32'hFFFF_FFFF, 32'hFFFF_FFFF);
        `CHK({lrs, fast, bsel, big, bad}, 7'b00_111_00)
        bus(0, 4'h0, 0, q);
        `CHK(q, 32'hFFFF_FFFF)
    endtask
    task t_order;
        logic [2:0] c[3] = '{3'h0, 3'h7, 3'h3};
        for (int i = 0; i < 3; i++) begin
            reboot(32'hFFFF_FFF8 | c[i], 32'hFFFF_FFFF);
            `CHK({bsel, big, bad}, {c[i], c[i] == 3'h0, c[i] == 3'h3})
            bus(0, 4'h0, 0, q);
            `CHK(q, 32'hFFFF_FFF8 | c[i])
        end
    endtask
    task t_erase;
        erased <= 1;
        reboot(32'h0000_0000, 32'h0000_0000);
        bus(0, 4'h2, 0, q);
        `CHK(q, 32'hFFFF_FFFF)
        bus(0, 4'h0, 0, q);
        `CHK(q, 32'hFFFF_FFFF)
        erased <= 0;
    endtask
    task t_boot;
        boot <= 1;
        reboot(32'hFFFF_FFFF, 32'hFFFF_FEF8);
        bus(0, 4'h2, 0, q);
        `CHK({q, fast, lrs}, {32'hFFFF_FFFF, 2'b00})
        boot <= 0;
    endtask
    task t_bus;
        reboot(32'hFFFF_FFF8, 32'hFFFF_FEF9);
        bus(1, 4'h0, 32'h1234_5678, q);
        bus(1, 4'h2, 32'h0000_0000, q);
        bus(0, 4'h0, 0, q);
        `CHK(q, 32'hFFFF_FFF8)
        bus(0, 4'h2, 0, q);
        `CHK(q, 32'hFFFF_FEF9)
        bus(0, 4'h4, 0, q);
        `CHK(q, 32'h0000_0001)
        bus(1, 4'h5, 32'h0000_0003, q);
        bus(0, 4'h5, 0, q);
        `CHK({q[2:0], src}, 6'o33)
        bus(0, 4'h9, 0, q);
        `CHK(q, 32'h0000_0000)
    endtask
    task t_mon;
        reboot(32'hFFFF_FFFF, 32'hFFFF_FEF8);
        below <= 1;
        for (n = 0; n < 20 && mres !== 1'b1; n++) @(posedge clk);
        `CHK({mres, rel}, 2'b10)
        below <= 0;
        for (n = 0; n < 50 && rel !== 1'b1; n++) @(posedge clk);
        `CHK({mres, rel}, 2'b01)
    endtask
    initial begin
        t_blank;
        t_level;
        t_order;
        t_erase;
        t_boot;
        t_bus;
        t_mon;
        final_report;
    end
endmodule // testbench
